/* common/reset_seq_pkg.sv */
// constants shared by the reset source sequencer and its delay timer
package reset_seq_pkg;

  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;

  // ----------------------------------------------------------------
  // timing: times in their own unit, counts derived from the clock
  // ----------------------------------------------------------------
  // brownout_min_pulse: a dip must outlast this before it resets
  localparam int unsigned BROWNOUT_MIN_PULSE_NS = 2000;
  localparam int unsigned BROWNOUT_MIN_CYCLES   =
    (BROWNOUT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // startup_delay_period choices, least times so round up
  localparam int unsigned DELAY_SEL0_NS = 4000;
  localparam int unsigned DELAY_SEL1_NS = 4100000;
  localparam int unsigned DELAY_SEL2_NS = 65000000;
  localparam int unsigned DELAY_SEL3_NS = 8000;
  localparam int unsigned OSC_SETTLE_NS = 65536;
  localparam int unsigned DELAY_SEL0_CYCLES = (DELAY_SEL0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DELAY_SEL1_CYCLES = (DELAY_SEL1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DELAY_SEL2_CYCLES = (DELAY_SEL2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DELAY_SEL3_CYCLES = (DELAY_SEL3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC_SETTLE_CYCLES = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DELAY_W = 25;

  // ----------------------------------------------------------------
  // brown-out level fuse coding
  // ----------------------------------------------------------------
  localparam logic [2:0] BOD_CODE_OFF  = 3'h7;
  localparam logic [2:0] BOD_CODE_LOW  = 3'h6;
  localparam logic [2:0] BOD_CODE_MID  = 3'h5;
  localparam logic [2:0] BOD_CODE_HIGH = 3'h4;
  localparam logic [1:0] BOD_SEL_NONE  = 2'h0;
  localparam logic [1:0] BOD_SEL_LOW   = 2'h1;
  localparam logic [1:0] BOD_SEL_MID   = 2'h2;
  localparam logic [1:0] BOD_SEL_HIGH  = 2'h3;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 8;
  localparam logic [3:0]  ADDR_CTRL = 4'h0;
  localparam logic [3:0]  ADDR_STAT = 4'h4;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  // ctrl fields
  localparam int unsigned CTRL_BG_SEL_BIT = 0;
  // status fields
  localparam int unsigned STAT_POR_BIT     = 0;
  localparam int unsigned STAT_EXT_BIT     = 1;
  localparam int unsigned STAT_WDT_BIT     = 2;
  localparam int unsigned STAT_BOD_BIT     = 3;
  localparam int unsigned STAT_SCAN_BIT    = 4;
  localparam int unsigned STAT_STRETCH_BIT = 5;
  localparam int unsigned STAT_BOD_EN_BIT  = 6;
  localparam int unsigned STAT_BOD_RSV_BIT = 7;
  localparam int unsigned NUM_SOURCES      = 5;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_STRETCH,
    SEQ_RUN
  } seq_state_e;

endpackage : reset_seq_pkg

/* common/delay_timer_if.sv */
// handshake between the sequencer and its start-up delay timer
`timescale 1ns/1ns
`default_nettype none

interface delay_timer_if #(
  parameter int unsigned W = reset_seq_pkg::DELAY_W
);
  logic         start;
  logic         abort;
  logic [W-1:0] load;
  logic         running;
  logic         done;

  modport ctrl  (output start, output abort, output load, input running, input done);
  modport timer (input start, input abort, input load, output running, output done);
endinterface : delay_timer_if

`default_nettype wire

/* design/startup_delay_timer.sv */
// start-up delay down-counter that stretches the internal reset
`timescale 1ns/1ns
`default_nettype none

module startup_delay_timer #(
  parameter int unsigned W = reset_seq_pkg::DELAY_W
) (
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire logic     ce_i,
  delay_timer_if.timer  tmr
);

  logic [W-1:0] count_q;
  logic         running_q;
  logic         done_q;

  // ----------------------------------------------------------------
  // counter: abort beats start, start reloads the full period
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q   <= '0;
      running_q <= 1'b0;
      done_q    <= 1'b0;
    end else if (ce_i) begin
      done_q <= 1'b0;
      if (tmr.abort) begin
        running_q <= 1'b0;
      end else if (tmr.start) begin
        count_q   <= tmr.load;
        running_q <= 1'b1;
      end else if (running_q) begin
        if (count_q <= W'(1)) begin
          running_q <= 1'b0;
          done_q    <= 1'b1;
        end else begin
          count_q <= count_q - W'(1);
        end
      end
    end
  end

  assign tmr.running = running_q;
  assign tmr.done    = done_q;

endmodule : startup_delay_timer

`default_nettype wire

/* design/reset_source_sequencer.sv */
// reset source combiner with start-up delay stretch and bandgap enable
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module reset_source_sequencer #(
  parameter int unsigned DELAY_SEL0_CYCLES = reset_seq_pkg::DELAY_SEL0_CYCLES,
  parameter int unsigned DELAY_SEL1_CYCLES = reset_seq_pkg::DELAY_SEL1_CYCLES,
  parameter int unsigned DELAY_SEL2_CYCLES = reset_seq_pkg::DELAY_SEL2_CYCLES,
  parameter int unsigned DELAY_SEL3_CYCLES = reset_seq_pkg::DELAY_SEL3_CYCLES,
  parameter int unsigned OSC_SETTLE_CYCLES = reset_seq_pkg::OSC_SETTLE_CYCLES
) (
  input  wire logic                              CLOCK_I,
  input  wire logic                              RESET_I,
  input  wire logic                              CE_I,
  input  wire logic                              POWER_LOW_I,
  input  wire logic                              EXT_RESET_N_I,
  input  wire logic                              WDT_EXPIRE_I,
  input  wire logic                              WDT_ENABLE_I,
  input  wire logic                              BROWNOUT_BELOW_I,
  input  wire logic                              SCAN_RESET_BIT_I,
  input  wire logic [2:0]                        BROWNOUT_LEVEL_FUSES_I,
  input  wire logic [1:0]                        STARTUP_TIME_FUSES_I,
  input  wire logic [3:0]                        CLOCK_SELECT_FUSES_I,
  input  wire logic                              ADC_ENABLE_I,
  input  wire logic [reset_seq_pkg::ADDR_W-1:0]  ADDR_I,
  input  wire logic [reset_seq_pkg::DATA_W-1:0]  WR_DATA_I,
  input  wire logic                              WR_STROBE_I,
  input  wire logic                              RD_STROBE_I,
  output logic [reset_seq_pkg::DATA_W-1:0]       RD_DATA_O,
  output logic                                   CORE_RESET_O,
  output logic                                   VECTOR_FETCH_O,
  output logic                                   BANDGAP_ENABLE_O,
  output logic                                   BROWNOUT_ENABLE_O,
  output logic [1:0]                             BROWNOUT_LEVEL_SEL_O
);

  localparam int unsigned DW = reset_seq_pkg::DELAY_W;
  localparam int unsigned BW = $clog2(reset_seq_pkg::BROWNOUT_MIN_CYCLES + 1);
  localparam logic [BW-1:0] BOD_MIN = BW'(reset_seq_pkg::BROWNOUT_MIN_CYCLES);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // brown-out fuse code to level select; reserved codes leave it off
  function automatic logic [1:0] bod_level(input logic [2:0] code);
    logic [1:0] sel;
    sel = reset_seq_pkg::BOD_SEL_NONE;
    unique case (code)
      reset_seq_pkg::BOD_CODE_LOW:  sel = reset_seq_pkg::BOD_SEL_LOW;
      reset_seq_pkg::BOD_CODE_MID:  sel = reset_seq_pkg::BOD_SEL_MID;
      reset_seq_pkg::BOD_CODE_HIGH: sel = reset_seq_pkg::BOD_SEL_HIGH;
      default:                      sel = reset_seq_pkg::BOD_SEL_NONE;
    endcase
    return sel;
  endfunction : bod_level

  // fuse settings to stretch length in system clock cycles
  function automatic logic [DW-1:0] delay_cycles(input logic [1:0] startup_time_fuses,
                                                 input logic [3:0] clock_select_fuses);
    logic [DW-1:0] base;
    base = DW'(DELAY_SEL0_CYCLES);
    unique case (startup_time_fuses)
      2'h0: base = DW'(DELAY_SEL0_CYCLES);
      2'h1: base = DW'(DELAY_SEL1_CYCLES);
      2'h2: base = DW'(DELAY_SEL2_CYCLES);
      2'h3: base = DW'(DELAY_SEL3_CYCLES);
    endcase
    // crystal selections add oscillator settling on top
    if (clock_select_fuses[3]) begin
      base = base + DW'(OSC_SETTLE_CYCLES);
    end
    return base;
  endfunction : delay_cycles

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                   async_src;
  logic                   any_src;
  logic [1:0]             bod_sel;
  logic                   bod_enabled;
  logic [BW-1:0]          bod_count_q;
  logic                   bod_fault_q;
  logic                   wdt_expire_prev_q;
  logic                   wdt_pulse_q;
  logic [reset_seq_pkg::DATA_W-1:0] ctrl_q;
  logic [reset_seq_pkg::DATA_W-1:0] status;
  reset_seq_pkg::seq_state_e        state_q;
  logic                   core_reset_q;
  logic                   fetch_q;
  logic                   bandgap_q;
  logic                   bod_en_q;
  logic [1:0]             bod_sel_q;
  logic [reset_seq_pkg::DATA_W-1:0] rd_data_q;

  delay_timer_if #(.W(DW)) tmr ();

  // ----------------------------------------------------------------
  // source combining
  // ----------------------------------------------------------------
  // these three need no clock; brownout waits for its filter
  assign async_src = POWER_LOW_I | ~EXT_RESET_N_I | SCAN_RESET_BIT_I;
  assign bod_sel     = bod_level(BROWNOUT_LEVEL_FUSES_I);
  assign bod_enabled = (bod_sel != reset_seq_pkg::BOD_SEL_NONE);
  assign any_src     = async_src | bod_fault_q | wdt_pulse_q;

  // ----------------------------------------------------------------
  // brown-out glitch filter
  // ----------------------------------------------------------------
  // dip must outlast the minimum pulse; recovery clears at once
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      bod_count_q <= '0;
      bod_fault_q <= 1'b0;
    end else if (CE_I) begin
      if (!(bod_enabled && BROWNOUT_BELOW_I)) begin
        bod_count_q <= '0;
        bod_fault_q <= 1'b0;
      end else if (bod_count_q < BOD_MIN) begin
        bod_count_q <= bod_count_q + BW'(1);
      end else begin
        bod_fault_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog pulse shaping
  // ----------------------------------------------------------------
  // edge detect so a held expiry still yields a single cycle
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      wdt_expire_prev_q <= 1'b0;
      wdt_pulse_q       <= 1'b0;
    end else if (CE_I) begin
      wdt_expire_prev_q <= WDT_EXPIRE_I;
      wdt_pulse_q       <= WDT_ENABLE_I & WDT_EXPIRE_I & ~wdt_expire_prev_q;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // the timer starts on the cycle all sources are seen clear
  always_comb begin
    tmr.start = 1'b0;
    tmr.abort = 1'b0;
    tmr.load  = delay_cycles(STARTUP_TIME_FUSES_I, CLOCK_SELECT_FUSES_I);
    unique case (state_q)
      reset_seq_pkg::SEQ_HOLD:    tmr.start = ~any_src;
      reset_seq_pkg::SEQ_STRETCH: tmr.abort = any_src;
      reset_seq_pkg::SEQ_RUN:     tmr.abort = 1'b0;
      default:                    tmr.abort = 1'b1;
    endcase
  end

  // state advance; a source and the final count in one cycle: source wins
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      state_q <= reset_seq_pkg::SEQ_HOLD;
    end else if (CE_I) begin
      unique case (state_q)
        reset_seq_pkg::SEQ_HOLD: begin
          if (!any_src) begin
            state_q <= reset_seq_pkg::SEQ_STRETCH;
          end
        end
        reset_seq_pkg::SEQ_STRETCH: begin
          if (any_src) begin
            state_q <= reset_seq_pkg::SEQ_HOLD;
          end else if (tmr.done) begin
            state_q <= reset_seq_pkg::SEQ_RUN;
          end
        end
        reset_seq_pkg::SEQ_RUN: begin
          if (any_src) begin
            state_q <= reset_seq_pkg::SEQ_HOLD;
          end
        end
        default: state_q <= reset_seq_pkg::SEQ_HOLD;
      endcase
    end
  end

  // core reset: preset without clock, released only after the stretch
  always_ff @(posedge CLOCK_I or posedge async_src) begin
    if (async_src) begin
      core_reset_q <= 1'b1;
    end else if (RESET_I) begin
      core_reset_q <= 1'b1;
    end else if (CE_I) begin
      if (any_src) begin
        core_reset_q <= 1'b1;
      end else if (state_q == reset_seq_pkg::SEQ_STRETCH && tmr.done) begin
        core_reset_q <= 1'b0;
      end
    end
  end

  // one-cycle fetch request from the reset vector on release
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      fetch_q <= 1'b0;
    end else if (CE_I) begin
      fetch_q <= (state_q == reset_seq_pkg::SEQ_STRETCH) & tmr.done & ~any_src;
    end
  end

  startup_delay_timer #(
    .W     (DW)
  ) u_timer (
    .clk_i (CLOCK_I),
    .rst_i (RESET_I),
    .ce_i  (CE_I),
    .tmr   (tmr.timer)
  );

  // ----------------------------------------------------------------
  // reference and brown-out enables
  // ----------------------------------------------------------------
  // bandgap follows its three users; users must allow it to settle
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      bandgap_q <= 1'b0;
      bod_en_q  <= 1'b0;
      bod_sel_q <= reset_seq_pkg::BOD_SEL_NONE;
    end else if (CE_I) begin
      bandgap_q <= bod_enabled | ctrl_q[reset_seq_pkg::CTRL_BG_SEL_BIT] | ADC_ENABLE_I;
      bod_en_q  <= bod_enabled;
      bod_sel_q <= bod_sel;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // control register returns to its initial value during core reset
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      ctrl_q <= reset_seq_pkg::CTRL_RESET;
    end else if (CE_I) begin
      if (core_reset_q) begin
        ctrl_q <= reset_seq_pkg::CTRL_RESET;
      end else if (WR_STROBE_I && ADDR_I == reset_seq_pkg::ADDR_CTRL) begin
        ctrl_q <= WR_DATA_I & 8'h01;
      end
    end
  end

  // live status of every source and of the stretch
  always_comb begin
    status = '0;
    status[reset_seq_pkg::STAT_POR_BIT]     = POWER_LOW_I;
    status[reset_seq_pkg::STAT_EXT_BIT]     = ~EXT_RESET_N_I;
    status[reset_seq_pkg::STAT_WDT_BIT]     = wdt_pulse_q;
    status[reset_seq_pkg::STAT_BOD_BIT]     = bod_fault_q;
    status[reset_seq_pkg::STAT_SCAN_BIT]    = SCAN_RESET_BIT_I;
    status[reset_seq_pkg::STAT_STRETCH_BIT] = tmr.running;
    status[reset_seq_pkg::STAT_BOD_EN_BIT]  = bod_enabled;
    status[reset_seq_pkg::STAT_BOD_RSV_BIT] = ~bod_enabled &
      (BROWNOUT_LEVEL_FUSES_I != reset_seq_pkg::BOD_CODE_OFF);
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      rd_data_q <= '0;
    end else if (CE_I) begin
      rd_data_q <= '0;
      if (RD_STROBE_I) begin
        unique case (ADDR_I)
          reset_seq_pkg::ADDR_CTRL: rd_data_q <= ctrl_q;
          reset_seq_pkg::ADDR_STAT: rd_data_q <= status;
          default:                  rd_data_q <= '0;   // unmapped reads zero
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RD_DATA_O            = rd_data_q;
  assign CORE_RESET_O         = core_reset_q;
  assign VECTOR_FETCH_O       = fetch_q;
  assign BANDGAP_ENABLE_O     = bandgap_q;
  assign BROWNOUT_ENABLE_O    = bod_en_q;
  assign BROWNOUT_LEVEL_SEL_O = bod_sel_q;

endmodule : reset_source_sequencer

`default_nettype wire

/* testbench/reset_seq_sva.sv */
// assertions on the ports of the reset source sequencer
`timescale 1ns/1ns
`default_nettype none
module reset_seq_sva #(
  parameter int unsigned DLY = 8
) (
  input wire logic       CLOCK_I,
  input wire logic       RESET_I,
  input wire logic       POWER_LOW_I,
  input wire logic       EXT_RESET_N_I,
  input wire logic       WDT_EXPIRE_I,
  input wire logic       WDT_ENABLE_I,
  input wire logic       BROWNOUT_BELOW_I,
  input wire logic       SCAN_RESET_BIT_I,
  input wire logic [2:0] BROWNOUT_LEVEL_FUSES_I,
  input wire logic [1:0] STARTUP_TIME_FUSES_I,
  input wire logic [3:0] CLOCK_SELECT_FUSES_I,
  input wire logic       ADC_ENABLE_I,
  input wire logic       CORE_RESET_O,
  input wire logic       VECTOR_FETCH_O,
  input wire logic       BANDGAP_ENABLE_O,
  input wire logic       BROWNOUT_ENABLE_O,
  input wire logic [1:0] BROWNOUT_LEVEL_SEL_O
);
  logic       async_src;
  logic       bod_exp;
  logic [1:0] sel_exp;
  logic [5:0] clr_cnt_q;
  logic [9:0] bel_cnt_q;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  // asynchronous sources and the expected fuse decode
  always_comb begin
    async_src = POWER_LOW_I | ~EXT_RESET_N_I | SCAN_RESET_BIT_I;
    bod_exp   = BROWNOUT_LEVEL_FUSES_I inside {3'h4, 3'h5, 3'h6};
    case (BROWNOUT_LEVEL_FUSES_I)
      reset_seq_pkg::BOD_CODE_LOW:  sel_exp = reset_seq_pkg::BOD_SEL_LOW;
      reset_seq_pkg::BOD_CODE_MID:  sel_exp = reset_seq_pkg::BOD_SEL_MID;
      reset_seq_pkg::BOD_CODE_HIGH: sel_exp = reset_seq_pkg::BOD_SEL_HIGH;
      default:                      sel_exp = reset_seq_pkg::BOD_SEL_NONE;
    endcase
  end

  // quiet cycles in a row; saturates so it never wraps into a false hit
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I || async_src || BROWNOUT_BELOW_I || WDT_EXPIRE_I) begin
      clr_cnt_q <= 6'h00;
    end else if (clr_cnt_q != 6'h3f) begin
      clr_cnt_q <= clr_cnt_q + 6'h01;
    end
  end

  // length of the present brown-out indication
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I || !BROWNOUT_BELOW_I) begin
      bel_cnt_q <= 10'h000;
    end else if (bel_cnt_q != 10'h3ff) begin
      bel_cnt_q <= bel_cnt_q + 10'h001;
    end
  end

  a_async_hold: assert property (async_src |-> CORE_RESET_O)
    else $error("core reset low while a source is active");
  a_vector_on_release: assert property ($fell(CORE_RESET_O) |-> VECTOR_FETCH_O ##1 !VECTOR_FETCH_O)
    else $error("fetch pulse missing at reset release");
  a_no_early_release: assert property ($fell(CORE_RESET_O) |-> clr_cnt_q >= DLY + 1)
    else $error("reset released before the delay ran out");
  a_release_bound: assert property (STARTUP_TIME_FUSES_I == 2'h0
    && !CLOCK_SELECT_FUSES_I[3] && clr_cnt_q == DLY + 8 |-> !CORE_RESET_O)
    else $error("reset still held long after all sources cleared");
  a_wdt_fires: assert property ($rose(WDT_EXPIRE_I) && WDT_ENABLE_I |-> ##[0:2] CORE_RESET_O)
    else $error("watchdog expiry gave no reset");
  a_no_spurious: assert property (!CORE_RESET_O && !async_src && bel_cnt_q < 10'd400
    && (!WDT_ENABLE_I || !WDT_EXPIRE_I) && (!WDT_ENABLE_I || !$past(WDT_EXPIRE_I))
    |=> !CORE_RESET_O || async_src || RESET_I)
    else $error("reset without a qualifying source");
  a_bod_trigger: assert property (BROWNOUT_ENABLE_O && bel_cnt_q == 10'd505 |-> CORE_RESET_O)
    else $error("long brown-out gave no reset");
  a_bod_decode: assert property ($stable(BROWNOUT_LEVEL_FUSES_I) && !$past(RESET_I)
    |-> BROWNOUT_ENABLE_O == bod_exp)
    else $error("brown-out enable does not match fuse code");
  a_level_decode: assert property ($stable(BROWNOUT_LEVEL_FUSES_I) && !$past(RESET_I)
    |-> BROWNOUT_LEVEL_SEL_O == sel_exp)
    else $error("brown-out level select does not match fuse code");
  a_bandgap_on: assert property ($stable(BROWNOUT_LEVEL_FUSES_I) && $stable(ADC_ENABLE_I)
    && !$past(RESET_I) && (bod_exp || ADC_ENABLE_I) |-> ##1 BANDGAP_ENABLE_O)
    else $error("bandgap off while a user needs it");
endmodule : reset_seq_sva
`default_nettype wire

/* testbench/reset_src_model.sv */
// far side: supply monitors, reset pin, watchdog and test port
`timescale 1ns/1ns
`default_nettype none
module reset_src_model (
  input  wire logic clk_i,
  input  wire logic por_low_i,
  input  wire logic pin_low_i,
  input  wire logic scan_i,
  input  wire logic below_i,
  input  wire logic fire_i,
  output logic      power_low_o,
  output logic      ext_reset_n_o,
  output logic      scan_bit_o,
  output logic      below_o,
  output logic      wdt_expire_o
);
  // monitors report levels; a released pin floats up to its pull-up
  assign power_low_o   = por_low_i;
  assign ext_reset_n_o = ~pin_low_i;
  assign scan_bit_o    = scan_i;
  assign below_o       = below_i;
  // expiry is a one-cycle strobe from the watchdog timer
  assign wdt_expire_o  = fire_i;
endmodule : reset_src_model
`default_nettype wire

/* testbench/reset_source_sequencer_tb.sv */
// self-checking bench for the reset source sequencer
`timescale 1ns/1ns
`default_nettype none
module reset_source_sequencer_tb;
  localparam int unsigned N0 = 8;
  logic       clk, rst, wdt_en, adc, wr_s, rd_s, por, pin, scan, below, fire, ce;
  logic       core, vec, bg, ben, pl, ern, wexp, bbel, sbit;
  logic [2:0] bfuse;
  logic [1:0] startup_time_fuses, bsel;
  logic [3:0] cks, addr;
  logic [7:0] wdata, rdata, d;
  int         err_count, n_compared, cyc, n, i;

  reset_src_model src_u (.clk_i(clk), .por_low_i(por), .pin_low_i(pin), .scan_i(scan),
    .below_i(below), .fire_i(fire), .power_low_o(pl), .ext_reset_n_o(ern),
    .scan_bit_o(sbit), .below_o(bbel), .wdt_expire_o(wexp));

  reset_source_sequencer #(.DELAY_SEL0_CYCLES(8), .DELAY_SEL1_CYCLES(12),
    .DELAY_SEL2_CYCLES(16), .DELAY_SEL3_CYCLES(10), .OSC_SETTLE_CYCLES(6)) dut_u (
    .CLOCK_I(clk), .RESET_I(rst), .CE_I(ce), .POWER_LOW_I(pl), .EXT_RESET_N_I(ern),
    .WDT_EXPIRE_I(wexp), .WDT_ENABLE_I(wdt_en), .BROWNOUT_BELOW_I(bbel),
    .SCAN_RESET_BIT_I(sbit), .BROWNOUT_LEVEL_FUSES_I(bfuse), .STARTUP_TIME_FUSES_I(startup_time_fuses),
    .CLOCK_SELECT_FUSES_I(cks), .ADC_ENABLE_I(adc), .ADDR_I(addr), .WR_DATA_I(wdata),
    .WR_STROBE_I(wr_s), .RD_STROBE_I(rd_s), .RD_DATA_O(rdata), .CORE_RESET_O(core),
    .VECTOR_FETCH_O(vec), .BANDGAP_ENABLE_O(bg), .BROWNOUT_ENABLE_O(ben),
    .BROWNOUT_LEVEL_SEL_O(bsel));

  // free-running system clock, 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_n

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic set_src(input int k, input logic v);
    case (k)
      0:       por  <= v;
      1:       pin  <= v;
      default: scan <= v;
    endcase
  endtask : set_src

  // edges until the core reset drops; the fetch pulse stands then
  task automatic rel(input int lo, input int hi);
    n = 0;
    while (core === 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_n(n, lo, hi);
    chk(8'(vec), 8'h01);
  endtask : rel

  initial begin
    {ce, rst, wdt_en, adc, wr_s, rd_s, por, pin, scan, below, fire} = 11'h600;
    {bfuse, startup_time_fuses, cks, addr, wdata} = 21'h1c_0000;
    {err_count, n_compared, cyc} = 96'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rel(N0 + 2, N0 + 3);
    rd(reset_seq_pkg::ADDR_CTRL);
    chk(d, reset_seq_pkg::CTRL_RESET);
    // every fuse code, with its effect on the bandgap
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      bfuse <= 3'(i);
      repeat (3) @(posedge clk);
      #1;
      chk(8'(ben), 8'(i inside {4, 5, 6}));
      chk(8'(bsel), (i == 6) ? 8'h01 : (i == 5) ? 8'h02 : (i == 4) ? 8'h03 : 8'h00);
      chk(8'(bg), 8'(i inside {4, 5, 6}));
    end
    adc <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(8'(bg), 8'h01);
    adc <= 1'b0;
    wr(reset_seq_pkg::ADDR_CTRL, 8'h01);
    rd(reset_seq_pkg::ADDR_CTRL);
    chk(d, 8'h01);
    chk(8'(bg), 8'h01);
    rd(4'h8);
    chk(d, 8'h00);
    wr(reset_seq_pkg::ADDR_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk(8'(bg), 8'h00);
    // power, pin and scan sources: immediate hold, then a full stretch
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      set_src(i, 1'b1);
      #1;
      chk(8'(core), 8'h01);
      wr(reset_seq_pkg::ADDR_CTRL, 8'h01);
      rd(reset_seq_pkg::ADDR_STAT);
      chk(8'(d[(i == 2) ? 4 : i]), 8'h01);
      rd(reset_seq_pkg::ADDR_CTRL);
      chk(d, 8'h00);
      @(posedge clk);
      set_src(i, 1'b0);
      rel(N0 + 2, N0 + 2);
    end
    // start-up and clock-select fuses pick a longer delay
    for (i = 1; i < 4; i++) begin
      startup_time_fuses <= 2'(i);
      cks <= 4'h8;
      @(posedge clk);
      por <= 1'b1;
      @(posedge clk);
      por <= 1'b0;
      n = (i == 1) ? 12 : (i == 2) ? 16 : 10;
      rel(n + 6 + 2, n + 6 + 2);
    end
    startup_time_fuses <= 2'h0;
    cks <= 4'h0;
    // watchdog: enabled expiry resets, disabled expiry does not
    wdt_en <= 1'b1;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(8'(core), 8'h01);
    rel(N0, N0 + 3);
    wdt_en <= 1'b0;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk(8'(core), 8'h00);
    // brown-out: a short dip is ignored, a long one resets
    bfuse <= reset_seq_pkg::BOD_CODE_LOW;
    @(posedge clk);
    below <= 1'b1;
    repeat (100) @(posedge clk);
    below <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk(8'(core), 8'h00);
    below <= 1'b1;
    repeat (520) @(posedge clk);
    #1;
    chk(8'(core), 8'h01);
    below <= 1'b0;
    rel(N0 + 2, N0 + 6);
    // a source in mid-stretch restarts the full delay
    @(posedge clk);
    por <= 1'b1;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    repeat (4) @(posedge clk);
    pin <= 1'b1;
    repeat (2) @(posedge clk);
    pin <= 1'b0;
    rel(N0 + 2, N0 + 2);
    // clock enable low freezes the running stretch count
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    rel(N0 - 1, N0 - 1);
    complete_run;
  end
endmodule : reset_source_sequencer_tb

bind reset_source_sequencer reset_seq_sva sva_u (
  .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .POWER_LOW_I(POWER_LOW_I),
  .EXT_RESET_N_I(EXT_RESET_N_I), .WDT_EXPIRE_I(WDT_EXPIRE_I), .WDT_ENABLE_I(WDT_ENABLE_I),
  .BROWNOUT_BELOW_I(BROWNOUT_BELOW_I), .SCAN_RESET_BIT_I(SCAN_RESET_BIT_I),
  .BROWNOUT_LEVEL_FUSES_I(BROWNOUT_LEVEL_FUSES_I), .STARTUP_TIME_FUSES_I(STARTUP_TIME_FUSES_I),
  .CLOCK_SELECT_FUSES_I(CLOCK_SELECT_FUSES_I), .ADC_ENABLE_I(ADC_ENABLE_I),
  .CORE_RESET_O(CORE_RESET_O), .VECTOR_FETCH_O(VECTOR_FETCH_O),
  .BANDGAP_ENABLE_O(BANDGAP_ENABLE_O), .BROWNOUT_ENABLE_O(BROWNOUT_ENABLE_O),
  .BROWNOUT_LEVEL_SEL_O(BROWNOUT_LEVEL_SEL_O));
`default_nettype wire
